// ==== rtl/mdu_pkg.sv ====
// shared constants and types of the multiply/divide unit
package mdu_pkg;
   // **********************************************************
   // register select codes
   // **********************************************************
   localparam logic [2:0] MDU_SEL_B0 = 3'h0;
   localparam logic [2:0] MDU_SEL_B1 = 3'h1;
   localparam logic [2:0] MDU_SEL_B2 = 3'h2;
   localparam logic [2:0] MDU_SEL_B3 = 3'h3;
   localparam logic [2:0] MDU_SEL_B4 = 3'h4;
   localparam logic [2:0] MDU_SEL_B5 = 3'h5;
   localparam logic [2:0] MDU_SEL_STATUS = 3'h6;
   localparam int MDU_NUM_DATA = 6;
   // **********************************************************
   // status register layout
   // **********************************************************
   localparam int MDU_ERR_BIT = 7;
   localparam int MDU_OVF_BIT = 6;
   // **********************************************************
   // timing in system clock periods
   // **********************************************************
   localparam logic [4:0] MDU_CYC_DIV32 = 5'h11;
   localparam logic [4:0] MDU_CYC_DIV16 = 5'h09;
   localparam logic [4:0] MDU_CYC_MUL = 5'h0B;
   localparam logic [15:0] MDU_HALF_MAX = 16'hFFFF;
   typedef enum logic [1:0] {MDU_OP_NONE, MDU_OP_DIV32, MDU_OP_DIV16, MDU_OP_MUL} mdu_op_e;
endpackage : mdu_pkg

// ==== rtl/mdu_if.sv ====
// byte register bus between core and multiply/divide unit
`timescale 1ns/10ps
interface mdu_if;
   logic wr;
   logic rd;
   logic [2:0] sel;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic busy;
   modport device (input wr, input rd, input sel, input wdata, output rdata, output busy);
   modport host (output wr, output rd, output sel, output wdata, input rdata, input busy);
endinterface : mdu_if

// ==== rtl/mdu_core.sv ====
// multiply/divide unit: device end of the byte register bus
//
// Contract
// RULE1 - host writes low byte before high byte
// RULE2 - start only on byte5 completing valid order
// RULE3 - gaps between sequence writes are tolerated
// RULE4 - writes 0..5 ascending select 32/16 divide
// RULE5 - writes 0,1,4,5 select 16/16 divide
// RULE6 - writes 0,4,1,5 select 16x16 multiply
// RULE7 - takes 17, 9 or 11 clocks
// RULE8 - host leaves data bytes alone while busy
// RULE9 - host checks status before reading results
// RULE10 - results read in fixed order, gaps allowed
// RULE11 - long divide: quotient 0..3, remainder 4..5
// RULE12 - short divide: quotient 0..1, remainder 4..5
// RULE13 - multiply: product bytes 0..3, low first
// RULE14 - no sleep before computation completes
// RULE15 - access while busy sets error, status read clears
// RULE16 - overflow updated on completion each operation; the unit updates it at launch instead
// RULE17 - bad order launches nothing; byte0 restarts tracking
`timescale 1ns/10ps
module mdu_core
   import mdu_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   mdu_if.device bus
);
   import mdu_pkg::*;

   // **********************************************************
   // sequence tracking
   // **********************************************************
   // history of data writes since the last byte0 write, one code per step
   logic [2:0] step_q, step_d;
   logic [2:0] h1_q, h2_q, h3_q, h4_q;
   logic [7:0] data_q [MDU_NUM_DATA];
   logic [4:0] cnt_q;
   logic busy_q;
   mdu_op_e op_q;
   logic err_q;
   logic ovf_q;
   logic [7:0] rdata_q;
   logic [31:0] res_lo_q;
   logic [15:0] res_hi_q;

   wire data_sel = (bus.sel <= MDU_SEL_B5);
   wire data_wr = bus.wr && data_sel && !busy_q;
   wire data_acc = (bus.wr || bus.rd) && data_sel;
   wire stat_rd = bus.rd && (bus.sel == MDU_SEL_STATUS);
   wire [2:0] s = bus.sel;

   // RULE4 ascending six writes
   wire seq_div32 = (step_q == 3'h5) && h1_q == MDU_SEL_B1 && h2_q == MDU_SEL_B2
                    && h3_q == MDU_SEL_B3 && h4_q == MDU_SEL_B4;
   // RULE5 byte0, byte1, byte4, byte5
   wire seq_div16 = (step_q == 3'h3) && h1_q == MDU_SEL_B1 && h2_q == MDU_SEL_B4;
   // RULE6 byte0, byte4, byte1, byte5
   wire seq_mul = (step_q == 3'h3) && h1_q == MDU_SEL_B4 && h2_q == MDU_SEL_B1;
   // RULE2 launch only on byte5 write closing a match
   // RULE17 anything else falls through with no launch
   wire launch = data_wr && (s == MDU_SEL_B5) && (seq_div32 || seq_div16 || seq_mul);
   wire [4:0] launch_cyc = seq_div32 ? MDU_CYC_DIV32 : (seq_div16 ? MDU_CYC_DIV16 : MDU_CYC_MUL);
   wire mdu_op_e launch_op = seq_div32 ? MDU_OP_DIV32 : (seq_div16 ? MDU_OP_DIV16 : MDU_OP_MUL);

   // RULE17 byte0 restarts; overflow of history marks the sequence dead
   always_comb begin
      step_d = step_q;
      if (data_wr) begin
         if (s == MDU_SEL_B0) begin
            step_d = 3'h1;
         end else if (step_q != 3'h0 && step_q != 3'h7) begin
            step_d = step_q + 3'h1;
         end
      end
      if (launch) begin
         step_d = 3'h0;
      end
   end

   // RULE3 only data writes advance the history
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         step_q <= 3'h0;
         h1_q <= 3'h7;
         h2_q <= 3'h7;
         h3_q <= 3'h7;
         h4_q <= 3'h7;
      end else begin
         step_q <= step_d;
         if (data_wr) begin
            if (step_q == 3'h1) h1_q <= s;
            if (step_q == 3'h2) h2_q <= s;
            if (step_q == 3'h3) h3_q <= s;
            if (step_q == 3'h4) h4_q <= s;
         end
      end
   end

   // **********************************************************
   // arithmetic
   // **********************************************************
   // result formed combinationally; the cycle count models the latency
   wire [31:0] dvd32 = {data_q[3], data_q[2], data_q[1], data_q[0]};
   wire [15:0] dvd16 = {data_q[1], data_q[0]};
   wire [15:0] dvs = {data_q[5], data_q[4]};
   wire [15:0] mcd = {data_q[1], data_q[0]};
   wire [15:0] d5 = {bus.wdata, data_q[4]};
   wire dvs_zero = (d5 == 16'h0000);
   wire [31:0] q32 = dvs_zero ? 32'h0000_0000 : dvd32 / {16'h0000, d5};
   wire [15:0] r32 = dvs_zero ? 16'h0000 : 16'(dvd32 % {16'h0000, d5});
   wire [15:0] q16 = dvs_zero ? 16'h0000 : dvd16 / d5;
   wire [15:0] r16 = dvs_zero ? 16'h0000 : dvd16 % d5;
   wire [31:0] prod = mcd * d5;
   wire prod_big = (prod > {16'h0000, MDU_HALF_MAX});
   wire [31:0] launch_lo = seq_div32 ? q32 : (seq_div16 ? {16'h0000, q16} : prod);
   wire [15:0] launch_hi = seq_div32 ? r32 : (seq_div16 ? r16 : dvs);

   // **********************************************************
   // latency counter
   // **********************************************************
   // the counter holds the full period so busy stands exactly that many clocks
   wire cnt_last = busy_q && (cnt_q == 5'h01);

   // RULE7 latency loaded from the matched operation
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         busy_q <= 1'b0;
         cnt_q <= 5'h00;
         op_q <= MDU_OP_NONE;
      end else if (launch) begin
         busy_q <= 1'b1;
         cnt_q <= launch_cyc;
         op_q <= launch_op;
      end else if (busy_q) begin
         busy_q <= !cnt_last;
         cnt_q <= cnt_q - 5'h01;
      end
   end

   // computed in one step at launch; the counter alone provides the latency
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ovf_q <= 1'b0;
         res_lo_q <= 32'h0000_0000;
         res_hi_q <= 16'h0000;
      end else if (launch) begin
         // RULE16 overflow for product or zero divisor
         ovf_q <= (seq_mul ? prod_big : dvs_zero);
         res_lo_q <= launch_lo;
         res_hi_q <= launch_hi;
      end
   end

   // **********************************************************
   // data bytes
   // **********************************************************
   // mul keeps its multiplier bytes, div16 the untouched bytes 2 and 3
   wire put_quot_hi = cnt_last && (op_q != MDU_OP_DIV16);
   wire put_rem = cnt_last && (op_q != MDU_OP_MUL);

   // RULE11 RULE12 RULE13 results placed low byte first
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < MDU_NUM_DATA; i++) data_q[i] <= 8'h00;
      end else if (launch) begin
         data_q[MDU_SEL_B5] <= bus.wdata;
      end else if (cnt_last) begin
         data_q[MDU_SEL_B0] <= res_lo_q[7:0];
         data_q[MDU_SEL_B1] <= res_lo_q[15:8];
         if (put_quot_hi) begin
            data_q[MDU_SEL_B2] <= res_lo_q[23:16];
            data_q[MDU_SEL_B3] <= res_lo_q[31:24];
         end
         if (put_rem) begin
            data_q[MDU_SEL_B4] <= res_hi_q[7:0];
            data_q[MDU_SEL_B5] <= res_hi_q[15:8];
         end
      end else if (data_wr) begin
         data_q[s] <= bus.wdata;
      end
   end

   // **********************************************************
   // status and read port
   // **********************************************************
   // RULE15 set on busy access wins over a same-cycle clear
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         err_q <= 1'b0;
      end else if (busy_q && data_acc) begin
         err_q <= 1'b1;
      end else if (stat_rd && !busy_q) begin
         err_q <= 1'b0;
      end
   end

   // RULE10 data reads outside busy have no side effect, so order and gaps are free
   wire [7:0] stat_byte = {err_q, ovf_q, 6'h00};
   wire [7:0] rd_mux = data_sel ? (busy_q ? 8'h00 : data_q[s])
                       : (bus.sel == MDU_SEL_STATUS ? stat_byte : 8'h00);
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 8'h00;
      end else if (bus.rd) begin
         rdata_q <= rd_mux;
      end
   end

   assign bus.rdata = rdata_q;
   assign bus.busy = busy_q;
endmodule : mdu_core

// ==== rtl/mdu_host.sv ====
// multiply/divide unit: core end issuing one operation at a time
`timescale 1ns/10ps
module mdu_host
   import mdu_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic start,
   input wire mdu_pkg::mdu_op_e op,
   input wire logic [31:0] opa,
   input wire logic [15:0] opb,
   mdu_if.host bus,
   output logic done,
   output logic ok,
   output logic [31:0] res_lo,
   output logic [15:0] res_hi
);
   import mdu_pkg::*;

   typedef enum logic [2:0] {MDH_IDLE, MDH_WR, MDH_WAIT, MDH_STAT, MDH_RD, MDH_FIN} mdh_st_e;
   mdh_st_e st_q;
   mdu_op_e op_q;
   logic [2:0] idx_q;
   logic [2:0] last_sel_q;
   logic [31:0] a_q;
   logic [15:0] b_q;
   logic [31:0] lo_q;
   logic [15:0] hi_q;
   logic done_q, ok_q, wr_q, rd_q, pend_q;
   logic [2:0] sel_q;
   logic [7:0] wdata_q;

   // RULE1 RULE4 RULE5 RULE6 write order, low byte of each operand first
   function automatic logic [2:0] wr_sel(input mdu_op_e o, input logic [2:0] i);
      logic [2:0] r;
      r = i;
      if (o == MDU_OP_DIV16) r = (i < 3'h2) ? i : i + 3'h2;
      if (o == MDU_OP_MUL) begin
         r = (i == 3'h0) ? MDU_SEL_B0 : ((i == 3'h1) ? MDU_SEL_B4 : MDU_SEL_B1);
         if (i == 3'h3) r = MDU_SEL_B5;
      end
      return r;
   endfunction : wr_sel

   wire [2:0] nbytes = (op_q == MDU_OP_DIV32) ? 3'h6 : 3'h4;
   // RULE10 read order of results
   wire [2:0] rd_sel = (op_q == MDU_OP_DIV16 && idx_q > 3'h1) ? idx_q + 3'h2 : idx_q;
   wire [2:0] cur_wr = wr_sel(op_q, idx_q);
   wire [7:0] wbyte = (cur_wr < MDU_SEL_B4) ? a_q[8*cur_wr[1:0] +: 8] : b_q[8*cur_wr[0] +: 8];

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= MDH_IDLE;
         op_q <= MDU_OP_MUL;
         idx_q <= 3'h0;
         last_sel_q <= 3'h0;
         a_q <= 32'h0000_0000;
         b_q <= 16'h0000;
         lo_q <= 32'h0000_0000;
         hi_q <= 16'h0000;
         done_q <= 1'b0;
         ok_q <= 1'b0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         pend_q <= 1'b0;
         sel_q <= 3'h0;
         wdata_q <= 8'h00;
      end else begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         done_q <= 1'b0;
         pend_q <= rd_q;
         last_sel_q <= sel_q;
         case (st_q)
            MDH_IDLE: begin
               if (start && op != MDU_OP_NONE) begin
                  op_q <= op;
                  a_q <= opa;
                  b_q <= opb;
                  idx_q <= 3'h0;
                  lo_q <= 32'h0000_0000;
                  hi_q <= 16'h0000;
                  st_q <= MDH_WR;
               end
            end
            MDH_WR: begin
               wr_q <= 1'b1;
               sel_q <= cur_wr;
               wdata_q <= wbyte;
               if (idx_q == nbytes - 3'h1) begin
                  st_q <= MDH_WAIT;
               end
               idx_q <= idx_q + 3'h1;
            end
            MDH_WAIT: begin
               // RULE8 RULE14 keep off the data bytes until busy drops
               if (!wr_q && !bus.busy) begin
                  rd_q <= 1'b1;
                  sel_q <= MDU_SEL_STATUS;
                  st_q <= MDH_STAT;
               end
            end
            MDH_STAT: begin
               // RULE9 results fetched only with overflow and error clear
               if (pend_q) begin
                  ok_q <= !bus.rdata[MDU_ERR_BIT] && !bus.rdata[MDU_OVF_BIT];
                  idx_q <= 3'h0;
                  st_q <= (bus.rdata[MDU_ERR_BIT] || bus.rdata[MDU_OVF_BIT]) ? MDH_FIN : MDH_RD;
               end
            end
            MDH_RD: begin
               if (pend_q) begin
                  if (last_sel_q < MDU_SEL_B4) lo_q[8*last_sel_q[1:0] +: 8] <= bus.rdata;
                  else hi_q[8*last_sel_q[0] +: 8] <= bus.rdata;
                  if (idx_q == nbytes) st_q <= MDH_FIN;
               end else if (!rd_q && idx_q < nbytes) begin
                  rd_q <= 1'b1;
                  sel_q <= rd_sel;
                  idx_q <= idx_q + 3'h1;
               end
            end
            MDH_FIN: begin
               done_q <= 1'b1;
               st_q <= MDH_IDLE;
            end
            default: st_q <= MDH_IDLE;
         endcase
      end
   end

   assign bus.wr = wr_q;
   assign bus.rd = rd_q;
   assign bus.sel = sel_q;
   assign bus.wdata = wdata_q;
   assign done = done_q;
   assign ok = ok_q;
   assign res_lo = lo_q;
   assign res_hi = hi_q;
endmodule : mdu_host

// ==== tb/mdu_asserts.sv ====
// concurrent checks on the byte register bus between host and unit
`timescale 1ns/10ps
module mdu_asserts (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic wr,
   input wire logic rd,
   input wire logic [2:0] sel,
   input wire logic [7:0] rdata,
   input wire logic busy
);
   // ****************
   // order tracking
   // ****************
   logic [14:0] hist_q;
   logic [4:0] run_q;
   logic [4:0] exp_q;
   logic stat_q;
   wire logic data_wr = wr && !busy && (sel < 3'h6);
   wire logic last_wr = data_wr && (sel == 3'h5);
   wire logic go_d32 = last_wr && (hist_q == {3'h0, 3'h1, 3'h2, 3'h3, 3'h4});
   wire logic go_d16 = last_wr && (hist_q[8:0] == {3'h0, 3'h1, 3'h4});
   wire logic go_mul = last_wr && (hist_q[8:0] == {3'h0, 3'h4, 3'h1});
   wire logic go_any = go_d32 || go_d16 || go_mul;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hist_q <= 15'h0000;
         exp_q <= 5'h00;
      end else begin
         if (data_wr) hist_q <= {hist_q[11:0], sel};
         if (go_any) exp_q <= go_d32 ? 5'h11 : (go_d16 ? 5'h09 : 5'h0B);
      end
   end
   // cycles seen busy, and whether status was read since the last run
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         run_q <= 5'h00;
         stat_q <= 1'b0;
      end else begin
         run_q <= busy ? run_q + 5'h01 : 5'h00;
         stat_q <= busy ? 1'b0 : (stat_q || (rd && sel == 3'h6));
      end
   end
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   launch_busy_a: assert property (go_any |=> busy)
      else $error("launch did not raise busy");
   busy_cause_a: assert property ($rose(busy) |-> $past(go_any))
      else $error("busy rose without a valid launch");
   busy_len_a: assert property ($fell(busy) |-> run_q == exp_q)
      else $error("busy length wrong for operation");
   busy_quiet_a: assert property (busy |-> !wr && !rd)
      else $error("data access while busy");
   status_clean_a: assert property (rd && sel == 3'h6 |=> rdata[7] == 1'b0 && rdata[5:0] == 6'h00)
      else $error("status shows error or stray bits");
   rdata_hold_a: assert property (!rd |=> $stable(rdata))
      else $error("read data moved without a read");
   status_first_a: assert property (rd && sel < 3'h6 |-> stat_q)
      else $error("result read before status");
   low_first_a: assert property (last_wr |-> hist_q[2:0] == 3'h4 || hist_q[2:0] == 3'h1)
      else $error("high divisor byte before low byte");
endmodule : mdu_asserts

// ==== tb/mdu_test.sv ====
// bench: host joined to unit, plus a second unit driven directly
`timescale 1ns/10ps
module mdu_test;
   import mdu_pkg::*;
   typedef struct {
      mdu_op_e op;
      logic [31:0] a;
      logic [15:0] b;
      logic ok;
      logic [31:0] lo;
      logic [15:0] hi;
   } mdu_row_s;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic start = 1'b0;
   mdu_op_e op = MDU_OP_NONE;
   logic [31:0] opa = 32'h00000000;
   logic [15:0] opb = 16'h0000;
   logic done;
   logic ok;
   logic [31:0] res_lo;
   logic [15:0] res_hi;
   int num_errors = 0;
   int check_count = 0;
   int cyc = 0;
   mdu_row_s rows [8] = '{
      '{MDU_OP_DIV32, 32'h12345678, 16'h0100, 1'b1, 32'h00123456, 16'h0078},
      '{MDU_OP_DIV32, 32'hFFFFFFFF, 16'hFFFF, 1'b1, 32'h00010001, 16'h0000},
      '{MDU_OP_DIV32, 32'h12345678, 16'h0000, 1'b0, 32'h00000000, 16'h0000},
      '{MDU_OP_DIV16, 32'hABCD1234, 16'h0010, 1'b1, 32'h00000123, 16'h0004},
      '{MDU_OP_DIV16, 32'h0000FFFF, 16'h0001, 1'b1, 32'h0000FFFF, 16'h0000},
      '{MDU_OP_DIV16, 32'h0000FFFF, 16'h0000, 1'b0, 32'h00000000, 16'h0000},
      '{MDU_OP_MUL, 32'h000000FF, 16'h0101, 1'b1, 32'h0000FFFF, 16'h0000},
      '{MDU_OP_MUL, 32'h00001234, 16'h0010, 1'b0, 32'h00012340, 16'h0000}};
   mdu_if bus_a ();
   mdu_if bus_b ();
   mdu_host mdu_host_i (.mclk(mclk), .arst_n(arst_n), .start(start), .op(op), .opa(opa),
      .opb(opb), .bus(bus_a.host), .done(done), .ok(ok), .res_lo(res_lo), .res_hi(res_hi));
   mdu_core mdu_core_i (.mclk(mclk), .arst_n(arst_n), .bus(bus_a.device));
   mdu_core mdu_core_err_i (.mclk(mclk), .arst_n(arst_n), .bus(bus_b.device));
   mdu_asserts mdu_asserts_i (.mclk(mclk), .arst_n(arst_n), .wr(bus_a.wr), .rd(bus_a.rd),
      .sel(bus_a.sel), .rdata(bus_a.rdata), .busy(bus_a.busy));
   always #20 mclk = ~mclk;
   // ****************
   // tasks
   // ****************
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr_b(input logic [2:0] s, input logic [7:0] d);
      @(negedge mclk);
      bus_b.wr = 1'b1;
      bus_b.sel = s;
      bus_b.wdata = d;
      @(negedge mclk);
      bus_b.wr = 1'b0;
   endtask : wr_b
   task automatic rd_b(input logic [2:0] s, input logic [7:0] exp);
      @(negedge mclk);
      bus_b.rd = 1'b1;
      bus_b.sel = s;
      @(negedge mclk);
      bus_b.rd = 1'b0;
      check(32'(bus_b.rdata), 32'(exp));
   endtask : rd_b
   task automatic busy_len(output int len);
      len = 0;
      for (int i = 0; i < 40; i++) begin
         if (bus_b.busy === 1'b1) len++;
         else if (len > 0) break;
         @(negedge mclk);
      end
   endtask : busy_len
   // a hang counts as a mismatch
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         num_errors = num_errors + 1;
         complete_run();
      end
   end
   // ****************
   // sequence
   // ****************
   initial begin
      int len;
      logic [47:0] v;
      bus_b.wr = 1'b0;
      bus_b.rd = 1'b0;
      bus_b.sel = 3'h0;
      bus_b.wdata = 8'h00;
      repeat (6) @(negedge mclk);
      arst_n = 1'b1;
      check(32'(done), 32'h0);
      rd_b(3'h6, 8'h00);
      rd_b(3'h7, 8'h00);
      foreach (rows[i]) begin
         @(negedge mclk);
         op = rows[i].op;
         opa = rows[i].a;
         opb = rows[i].b;
         start = 1'b1;
         @(negedge mclk);
         start = 1'b0;
         for (int k = 0; k < 200 && done !== 1'b1; k++) @(negedge mclk);
         check(32'(done), 32'h1);
         check(32'(ok), 32'(rows[i].ok));
         if (rows[i].ok) check(res_lo, rows[i].lo);
         if (rows[i].ok && rows[i].op != MDU_OP_MUL) check(32'(res_hi), 32'(rows[i].hi));
      end
      // multiply with idle cycles between the writes
      wr_b(3'h0, 8'h12);
      repeat (3) @(negedge mclk);
      wr_b(3'h4, 8'h04);
      wr_b(3'h1, 8'h00);
      repeat (2) @(negedge mclk);
      wr_b(3'h5, 8'h03);
      busy_len(len);
      check(32'(len), 32'd11);
      rd_b(3'h6, 8'h00);
      for (int j = 0; j < 4; j++) rd_b(3'(j), 8'((32'h00003648 >> (8 * j)) & 32'hFF));
      // an unknown order launches nothing; byte0 starts tracking over
      wr_b(3'h0, 8'h01);
      wr_b(3'h4, 8'h01);
      wr_b(3'h5, 8'h01);
      repeat (3) @(negedge mclk);
      check(32'(bus_b.busy), 32'h0);
      wr_b(3'h1, 8'hAA);
      v = 48'h001087654321;
      for (int j = 0; j < 6; j++) wr_b(3'(j), v[8*j +: 8]);
      repeat (2) @(negedge mclk);
      rd_b(3'h0, 8'h00);
      wr_b(3'h1, 8'hFF);
      busy_len(len);
      rd_b(3'h6, 8'h80);
      rd_b(3'h6, 8'h00);
      v = 48'h000108765432;
      for (int j = 0; j < 6; j++) rd_b(3'(j), v[8*j +: 8]);
      complete_run();
   end
endmodule : mdu_test
